//--- rtl/lcdh_pkg.sv
// Purpose: Shared types and constants for the LCD host port block
// Assumes: One system clock, one serial link clock
// Notes:   Used as lcdh_pkg::name, never imported
package lcdh_pkg;

  // ****************************************************************
  // Widths and defaults
  // ****************************************************************
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned BIT_CNT_W  = 3;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam int unsigned LINE_W     = 8;
  localparam int unsigned LINES_DEF  = 65;
  localparam int unsigned DIV_W      = 8;
  // Half period of the internal display clock in system cycles
  localparam int unsigned OSC_HALF_DEF = 4;
  localparam int unsigned NPIN       = 13;

  // Positions in the synchronised pin vector
  localparam int unsigned P_PS   = 12;
  localparam int unsigned P_CSN  = 11;
  localparam int unsigned P_CS2  = 10;
  localparam int unsigned P_STY  = 9;
  localparam int unsigned P_DC   = 8;
  localparam int unsigned P_RD   = 7;
  localparam int unsigned P_WR   = 6;
  localparam int unsigned P_MS   = 5;
  localparam int unsigned P_CL   = 4;
  localparam int unsigned P_FR   = 3;
  localparam int unsigned P_SYN  = 2;
  localparam int unsigned P_PA   = 1;
  localparam int unsigned P_PB   = 0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic              dc;
    logic [BYTE_W-1:0] data;
  } lcdh_byte_t;

  typedef struct packed {
    logic booster;
    logic regulator;
    logic vf;
  } lcdh_power_t;

endpackage

//--- rtl/lcdh_serial_rx.sv
// Purpose: Serial receiver, runs on the serial clock
// Assumes: arst_n_i is low while reset or deselected, rst_n_i only in reset
// Notes:   Each finished byte flips done_tgl_o
`timescale 1ns/1ps
`default_nettype none
module lcdh_serial_rx (
  // Link
  input  wire logic               sclk_i,
  input  wire logic               arst_n_i,
  input  wire logic               rst_n_i,
  input  wire logic               si_i,
  input  wire logic               dc_i,
  // Result
  output lcdh_pkg::lcdh_byte_t    byte_o,
  output logic                    done_tgl_o
);

  // ****************************************************************
  // Shifter
  // ****************************************************************
  logic [lcdh_pkg::BIT_CNT_W-1:0] cnt;
  logic [lcdh_pkg::BYTE_W-2:0]    shreg;
  wire                            last = (cnt == lcdh_pkg::LAST_BIT);

  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt   <= '0; // see (R21)
      shreg <= '0;
    end else begin
      cnt   <= cnt + 3'h1; // see (R21)
      shreg <= {shreg[lcdh_pkg::BYTE_W-3:0], si_i}; // see (R8)
    end
  end

  // Result keeps its toggle across deselect, else a false byte would appear
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_o     <= '0;
      done_tgl_o <= 1'b0;
    end else if (last) begin
      byte_o     <= '{dc: dc_i, data: {shreg, si_i}}; // see (R21)
      done_tgl_o <= ~done_tgl_o; // see (R8)
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rx_byte;
    @(posedge sclk_i) disable iff (!arst_n_i)
    last |=> (done_tgl_o != $past(done_tgl_o)) && byte_o.dc == $past(dc_i);
  endproperty
  a_rx_byte: assert property (p_rx_byte) // see (R21)
    else $error("serial byte not finished on eighth edge");

  property p_rx_quiet;
    @(posedge sclk_i) disable iff (!arst_n_i)
    !last |=> $stable(done_tgl_o);
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) // see (R8)
    else $error("serial byte finished early");

endmodule // lcdh_serial_rx
`default_nettype wire

//--- rtl/lcdh_top.sv
// Purpose: Host port and display sync control of an LCD driver
// Assumes: Pins are asynchronous to clk_sys_i
// Notes:   Two-way pins split into in, out and active-low enable
// Notes on behaviour
// (R1) Data/command select low means control byte
// (R2) Reset pin low resets everything
// (R3) Bus used only when both selects active
// (R4) Style select low 8080, high 6800
// (R5) Read pin low-active 8080, enable 6800
// (R6) Write pin low-active 8080, direction 6800
// (R7) Parallel/serial select picks interface
// (R8) Serial data sampled on serial clock rise
// (R9) Serial mode never drives data back
// (R10) Host fixes unused interface pins
// (R11) Line counts on rise, pattern on fall
// (R12) External clock needs oscillator pins, reset
// (R13) Internal oscillator: display clock input tied low
// (R14) Oscillator amp pin role by primary select
// (R15) Primary runs oscillator, power, timing
// (R16) Primary drives display clock output
// (R17) AC phase pin output only as primary
// (R18) Frame sync pin output only as primary
// (R19) Power pins decode to circuit enables
// (R20) Start-up output begins common scan
// (R21) Eight edges per byte, clear when deselected
`timescale 1ns/1ps
`default_nettype none
module lcdh_top #(
  parameter int unsigned LINES    = lcdh_pkg::LINES_DEF,
  parameter int unsigned OSC_HALF = lcdh_pkg::OSC_HALF_DEF
) (
  // System
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_n_i,
  // Host bus pins
  input  wire logic                          par_serial_sel_i,
  input  wire logic                          chip_select_low_active_n_i,
  input  wire logic                          chip_select_high_active_i,
  input  wire logic                          bus_style_select_i,
  input  wire logic                          data_command_select_i,
  input  wire logic                          rd_strobe_i,
  input  wire logic                          wr_strobe_i,
  input  wire logic [lcdh_pkg::BYTE_W-1:0]   bus_data_i,
  output logic [lcdh_pkg::BYTE_W-1:0]        bus_data_o,
  output logic                               bus_data_oe_n_o,
  // Serial link
  input  wire logic                          serial_clk_i,
  input  wire logic                          serial_data_i,
  // Core side
  output lcdh_pkg::lcdh_byte_t               wr_byte_o,
  output logic                               wr_valid_o,
  input  wire logic [lcdh_pkg::BYTE_W-1:0]   rd_data_i,
  // Sync pins
  input  wire logic                          primary_sel_i,
  input  wire logic                          display_clock_in_i,
  output logic                               display_clock_out_o,
  input  wire logic                          ac_drive_phase_i,
  output logic                               ac_drive_phase_o,
  output logic                               ac_drive_phase_oe_n_o,
  input  wire logic                          frame_sync_i,
  output logic                               frame_sync_o,
  output logic                               frame_sync_oe_n_o,
  output logic                               osc_amp_pin_o,
  output logic                               osc_amp_pin_oe_n_o,
  output logic                               startup_o,
  // Display core timing
  output logic [lcdh_pkg::LINE_W-1:0]        line_o,
  output logic                               pattern_stb_o,
  // Power
  input  wire logic                          power_ctrl_a_i,
  input  wire logic                          power_ctrl_b_i,
  output logic                               osc_en_o,
  output lcdh_pkg::lcdh_power_t              power_en_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sr;
  wire        rst_n = rst_sr[1];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sr <= 2'h0; // see (R2)
    end else begin
      rst_sr <= {rst_sr[0], 1'b1};
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [lcdh_pkg::NPIN-1:0] pins = {
    par_serial_sel_i, chip_select_low_active_n_i,
    chip_select_high_active_i, bus_style_select_i,
    data_command_select_i, rd_strobe_i, wr_strobe_i,
    primary_sel_i, display_clock_in_i, ac_drive_phase_i,
    frame_sync_i, power_ctrl_a_i, power_ctrl_b_i};

  logic [lcdh_pkg::NPIN-1:0]   p1, p2, p3;
  logic [lcdh_pkg::BYTE_W-1:0] d1, d2;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      p1 <= '0;
      p2 <= '0;
      p3 <= '0;
      d1 <= '0;
      d2 <= '0;
    end else begin
      p1 <= pins;
      p2 <= p1;
      p3 <= p2;
      d1 <= bus_data_i;
      d2 <= d1;
    end
  end

  wire par   = p2[lcdh_pkg::P_PS];
  wire sel   = !p2[lcdh_pkg::P_CSN] && p2[lcdh_pkg::P_CS2];
  wire sty   = p2[lcdh_pkg::P_STY];
  wire dc    = p2[lcdh_pkg::P_DC];
  wire rd    = p2[lcdh_pkg::P_RD];
  wire wr    = p2[lcdh_pkg::P_WR];
  wire ms    = p2[lcdh_pkg::P_MS];
  wire cl    = p2[lcdh_pkg::P_CL];
  wire fr_in = p2[lcdh_pkg::P_FR];
  wire sy_in = p2[lcdh_pkg::P_SYN];
  wire pw_a  = p2[lcdh_pkg::P_PA];
  wire pw_b  = p2[lcdh_pkg::P_PB];
  wire rd_q  = p3[lcdh_pkg::P_RD];
  wire wr_q  = p3[lcdh_pkg::P_WR];
  wire sy_q  = p3[lcdh_pkg::P_SYN];

  // ****************************************************************
  // Parallel bus decode
  // ****************************************************************
  wire par_on = par && sel; // see (R3) (R7)
  // 8080: write taken at the trailing edge of the write strobe
  wire wr_8080 = !sty && wr && !wr_q; // see (R4) (R6)
  // 6800: write taken at the falling edge of enable, direction low
  wire wr_6800 = sty && !rd && rd_q && !wr; // see (R4) (R5) (R6)
  wire par_wr  = par_on && (wr_8080 || wr_6800);
  wire rd_act  = sty ? (rd && wr) : !rd; // see (R5) (R6)
  wire drive   = par_on && rd_act; // see (R9)

  // ****************************************************************
  // Serial link
  // ****************************************************************
  // Receiver is held clear while reset or not selected
  wire rx_arst_n = rst_n_i && !chip_select_low_active_n_i
                   && chip_select_high_active_i
                   && !par_serial_sel_i; // see (R21) (R7)

  lcdh_pkg::lcdh_byte_t rx_byte;
  logic                 rx_tgl;
  logic [2:0]           tgl_s;

  lcdh_serial_rx u_rx (
    .sclk_i     (serial_clk_i),
    .arst_n_i   (rx_arst_n),
    .rst_n_i    (rst_n_i),
    .si_i       (serial_data_i),
    .dc_i       (data_command_select_i),
    .byte_o     (rx_byte),
    .done_tgl_o (rx_tgl)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s <= 3'h0;
    end else begin
      tgl_s <= {tgl_s[1:0], rx_tgl};
    end
  end

  // Byte word is stable for eight serial clocks after the toggle
  wire ser_wr = (tgl_s[2] != tgl_s[1]) && !par; // see (R8)

  // ****************************************************************
  // Bus outputs
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_o      <= 1'b0;
      wr_byte_o       <= '0;
      bus_data_o      <= '0;
      bus_data_oe_n_o <= 1'b1;
    end else begin
      wr_valid_o      <= par_wr || ser_wr;
      if (par_wr) begin
        wr_byte_o <= '{dc: dc, data: d2}; // see (R1)
      end else if (ser_wr) begin
        wr_byte_o <= rx_byte; // see (R1)
      end
      bus_data_o      <= rd_data_i;
      bus_data_oe_n_o <= !drive; // see (R3) (R9)
    end
  end

  // ****************************************************************
  // Display clock
  // ****************************************************************
  logic [lcdh_pkg::DIV_W-1:0] div;
  logic                       int_clk;
  logic                       dclk_q;
  wire  div_end = (div == lcdh_pkg::DIV_W'(OSC_HALF - 1));
  // Internal clock runs only as primary; input is tied low then
  wire  dclk    = (ms && int_clk) || cl; // see (R13) (R15)
  wire  d_rise  = dclk && !dclk_q; // see (R11)
  wire  d_fall  = !dclk && dclk_q; // see (R11)

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      div     <= '0;
      int_clk <= 1'b0;
      dclk_q  <= 1'b0;
    end else begin
      dclk_q <= dclk;
      if (!ms || div_end) begin
        div <= '0;
      end else begin
        div <= div + 8'h1;
      end
      if (!ms) begin
        int_clk <= 1'b0; // see (R15)
      end else if (div_end) begin
        int_clk <= ~int_clk;
      end
    end
  end

  // ****************************************************************
  // Line counter and frame timing
  // ****************************************************************
  logic [lcdh_pkg::LINE_W-1:0] line;
  logic                        fr;
  wire  line_end = (line == lcdh_pkg::LINE_W'(LINES - 1));
  // Secondary restarts its frame on the primary's sync
  wire  sy_rise  = !ms && sy_in && !sy_q; // see (R18)

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      line <= '0;
      fr   <= 1'b0;
    end else begin
      if (sy_rise || (d_rise && line_end)) begin
        line <= '0; // see (R11)
      end else if (d_rise) begin
        line <= line + 8'h1; // see (R11)
      end
      if (!ms) begin
        fr <= fr_in; // see (R17)
      end else if (d_rise && line_end) begin
        fr <= ~fr; // see (R15)
      end
    end
  end

  // ****************************************************************
  // Sync and timing outputs
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      line_o                <= '0;
      pattern_stb_o         <= 1'b0;
      display_clock_out_o   <= 1'b0;
      ac_drive_phase_o      <= 1'b0;
      ac_drive_phase_oe_n_o <= 1'b1;
      frame_sync_o          <= 1'b0;
      frame_sync_oe_n_o     <= 1'b1;
      osc_amp_pin_o         <= 1'b0;
      osc_amp_pin_oe_n_o    <= 1'b1;
      startup_o             <= 1'b0;
    end else begin
      pattern_stb_o         <= d_fall; // see (R11)
      if (d_fall) begin
        line_o <= line; // see (R11)
      end
      display_clock_out_o   <= ms && dclk; // see (R16)
      ac_drive_phase_o      <= fr;
      ac_drive_phase_oe_n_o <= !ms; // see (R17)
      frame_sync_o          <= ms && (line == '0); // see (R18)
      frame_sync_oe_n_o     <= !ms; // see (R18)
      osc_amp_pin_o         <= ms && int_clk; // see (R14)
      osc_amp_pin_oe_n_o    <= !ms; // see (R14)
      startup_o             <= ms && (line == '0); // see (R20)
    end
  end

  // ****************************************************************
  // Power control
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_o   <= 1'b0;
      power_en_o <= '0;
    end else begin
      osc_en_o             <= ms; // see (R15)
      power_en_o.booster   <= ms && !pw_a; // see (R19)
      power_en_o.regulator <= ms && !(pw_a && pw_b); // see (R19)
      power_en_o.vf        <= ms; // see (R19) (R15)
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  property p_dc_kept;
    par_wr |=> wr_valid_o && wr_byte_o.dc == $past(dc);
  endproperty
  a_dc_kept: assert property (p_dc_kept) // see (R1)
    else $error("byte kind not taken from select pin");

  property p_desel_quiet;
    !sel && par |=> !wr_valid_o && bus_data_oe_n_o;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) // see (R3)
    else $error("bus used while deselected");

  property p_rd_8080;
    par_on && !sty && !rd |=> !bus_data_oe_n_o;
  endproperty
  a_rd_8080: assert property (p_rd_8080) // see (R5)
    else $error("8080 read not driven");

  property p_wr_6800;
    par_on && sty && rd && !wr |=> bus_data_oe_n_o;
  endproperty
  a_wr_6800: assert property (p_wr_6800) // see (R6)
    else $error("6800 write cycle drove the bus");

  property p_serial_no_rd;
    !par [*2] |=> bus_data_oe_n_o;
  endproperty
  a_serial_no_rd: assert property (p_serial_no_rd) // see (R9)
    else $error("data driven in serial mode");

  property p_power;
    ms && pw_a && pw_b |=> !power_en_o.booster
      && !power_en_o.regulator && power_en_o.vf;
  endproperty
  a_power: assert property (p_power) // see (R19)
    else $error("power decode wrong");

  property p_second;
    !ms |=> !osc_en_o && !power_en_o.vf && !display_clock_out_o
      && ac_drive_phase_oe_n_o && frame_sync_oe_n_o;
  endproperty
  a_second: assert property (p_second) // see (R15) (R16) (R17)
    else $error("secondary drives timing");

  property p_pattern;
    d_fall |=> pattern_stb_o && line_o == $past(line);
  endproperty
  a_pattern: assert property (p_pattern) // see (R11)
    else $error("pattern not issued on falling edge");

  property p_line_step;
    d_rise && !line_end && !sy_rise |=> line == $past(line) + 8'h1;
  endproperty
  a_line_step: assert property (p_line_step) // see (R11)
    else $error("line counter missed a rising edge");

  property p_primary_pins;
    ms [*2] |-> !frame_sync_oe_n_o && !osc_amp_pin_oe_n_o;
  endproperty
  a_primary_pins: assert property (p_primary_pins) // see (R18) (R14)
    else $error("primary not driving sync pins");

  c_par_wr:  cover property (par_wr ##1 wr_valid_o);
  c_ser_wr:  cover property (ser_wr ##1 wr_valid_o);
  c_read:    cover property (!bus_data_oe_n_o);
  c_frame:   cover property (ms && d_rise && line_end);

endmodule // lcdh_top
`default_nettype wire

//--- sim/lcd_driver_host_and_sync_control_test.sv
// Purpose: Self-checking bench of the LCD host port block
// Assumes: Host model drives host pins, bench drives sync and power pins
// Notes:   Line count shortened to 5 to reach the wrap
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_host_and_sync_control_test;
  localparam int unsigned LINES = 5;
  logic clk, rst_n, pri, dclk, acp, fsy, pa, pb, wv, oe_n, dco;
  logic aco, acoe, fso, fsoe, osco, oscoe, stu, pst, osce, c1, s1;
  logic [7:0] rdd, bdo, line, l0;
  logic [3:0] seen;
  wire logic ps, csn, cs2, sty, dc, rd, wr, sclk, si;
  wire logic [7:0] d;
  lcdh_pkg::lcdh_byte_t wb, got;
  lcdh_pkg::lcdh_power_t pw;
  int fails = 0;
  int num_checks = 0;
  int nval = 0;

  lcdh_host_model host_u (.clk_i(clk), .ps_o(ps), .csn_o(csn), .cs2_o(cs2),
    .sty_o(sty), .dc_o(dc), .rd_o(rd), .wr_o(wr), .d_o(d), .sclk_o(sclk),
    .si_o(si));
  lcdh_top #(.LINES(LINES)) dut_u (.clk_sys_i(clk), .rst_n_i(rst_n),
    .par_serial_sel_i(ps), .chip_select_low_active_n_i(csn),
    .chip_select_high_active_i(cs2), .bus_style_select_i(sty),
    .data_command_select_i(dc), .rd_strobe_i(rd), .wr_strobe_i(wr),
    .bus_data_i(d), .bus_data_o(bdo), .bus_data_oe_n_o(oe_n),
    .serial_clk_i(sclk), .serial_data_i(si), .wr_byte_o(wb),
    .wr_valid_o(wv), .rd_data_i(rdd), .primary_sel_i(pri),
    .display_clock_in_i(dclk), .display_clock_out_o(dco),
    .ac_drive_phase_i(acp), .ac_drive_phase_o(aco),
    .ac_drive_phase_oe_n_o(acoe), .frame_sync_i(fsy), .frame_sync_o(fso),
    .frame_sync_oe_n_o(fsoe), .osc_amp_pin_o(osco),
    .osc_amp_pin_oe_n_o(oscoe), .startup_o(stu), .line_o(line),
    .pattern_stb_o(pst), .power_ctrl_a_i(pa), .power_ctrl_b_i(pb),
    .osc_en_o(osce), .power_en_o(pw));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Captures every finished byte
  always @(posedge clk) begin
    if (wv === 1'b1) begin
      got <= wb;
      nval <= nval + 1;
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic par_case(input logic c, input logic [7:0] v, input int on);
    int n0;
    n0 = nval;
    host_u.pwr(c, v);
    cyc(6);
    chk(16'(nval), 16'(n0 + on));
    if (on == 1) chk(16'(got), {7'h00, c, v});
  endtask

  task automatic ser_case(input logic c, input logic [7:0] v);
    int n0;
    n0 = nval;
    host_u.ser(c, v, 8);
    cyc(8);
    chk(16'(nval), 16'(n0 + 1));
    chk(16'(got), {7'h00, c, v});
  endtask

  task automatic rd_case(input logic on);
    rdd = 8'($urandom);
    host_u.rd_on();
    cyc(6);
    chk(16'(oe_n), 16'(!on));
    if (on) chk(16'(bdo), 16'(rdd));
    host_u.rd_off();
    cyc(6);
    chk(16'(oe_n), 16'h0001);
  endtask

  initial begin
    rst_n = 1'b0;
    pri = 1'b0;
    dclk = 1'b0;
    acp = 1'b0;
    fsy = 1'b0;
    pa = 1'b0;
    pb = 1'b0;
    rdd = 8'h00;
    c1 = 1'b0;
    s1 = 1'b0;
    seen = 4'h0;
    void'($urandom(32'hd68f9078));
    cyc(2);
    chk(16'({oe_n, wv, acoe}), 16'h0005);
    rst_n = 1'b1;
    cyc(5);
    pri = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {pa, pb} = 2'(i);
      cyc(6);
      chk(16'(pw), {13'h0000, !pa, !(pa && pb), 1'b1});
    end
    chk(16'({osce, acoe, fsoe, oscoe}), 16'h0008);
    for (int i = 0; i < 200; i++) begin
      cyc(1);
      c1 = c1 | dco;
      s1 = s1 | stu;
      seen = seen | {osco, fso, pst, aco};
    end
    chk(16'({c1, s1}), 16'h0003);
    chk(16'(seen), 16'h000f);
    for (int s = 0; s < 2; s++) begin
      host_u.style(1'(s));
      par_case(1'b0, 8'h00, 1);
      par_case(1'b1, 8'hff, 1);
      for (int k = 0; k < 4; k++) par_case(1'($urandom), 8'($urandom), 1);
      rd_case(1'b1);
      host_u.sel(1'b1, 1'b1);
      par_case(1'b1, 8'h5a, 0);
      host_u.sel(1'b0, 1'b0);
      rd_case(1'b0);
      host_u.sel(1'b0, 1'b1);
    end
    host_u.mode(1'b0);
    rd_case(1'b0);
    ser_case(1'b0, 8'h80);
    for (int k = 0; k < 5; k++) ser_case(1'($urandom), 8'($urandom));
    host_u.ser(1'b1, 8'ha5, 3);
    host_u.sel(1'b1, 1'b1);
    cyc(3);
    host_u.sel(1'b0, 1'b1);
    ser_case(1'b1, 8'h3c);
    pri = 1'b0;
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(5);
    chk(16'({osce, dco, acoe, fsoe, oscoe}), 16'h0007);
    chk(16'(pw), 16'h0000);
    l0 = line;
    for (int k = 1; k < 8; k++) begin
      dclk = 1'b1;
      cyc(4);
      dclk = 1'b0;
      cyc(5);
      chk(16'(line), 16'((l0 + k) % LINES));
    end
    acp = 1'b1;
    cyc(5);
    chk(16'(aco), 16'h0001);
    end_of_test();
  end
endmodule // lcd_driver_host_and_sync_control_test
`default_nettype wire

//--- sim/lcdh_host_model.sv
// Purpose: Host processor model driving the parallel bus or serial link
// Assumes: Tasks are called from the bench, starting at a falling edge
// Notes:   Released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module lcdh_host_model (
  // Clock
  input  wire logic       clk_i,
  // Host pins
  output logic            ps_o,
  output logic            csn_o,
  output logic            cs2_o,
  output logic            sty_o,
  output logic            dc_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      d_o,
  output logic            sclk_o,
  output logic            si_o
);
  initial begin
    ps_o = 1'b1;
    csn_o = 1'b0;
    cs2_o = 1'b1;
    sty_o = 1'b0;
    dc_o = 1'b0;
    rd_o = 1'b1;
    wr_o = 1'b1;
    d_o = 8'h00;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic mode(input logic p);
    @(negedge clk_i);
    ps_o = p;
  endtask

  task automatic sel(input logic n, input logic h);
    @(negedge clk_i);
    csn_o = n;
    cs2_o = h;
  endtask

  task automatic style(input logic s);
    @(negedge clk_i);
    sty_o = s;
    rd_o = !s;
    wr_o = 1'b1;
  endtask

  // Write strobes are held 4 cycles, above the 3-cycle minimum
  task automatic pwr(input logic dc, input logic [7:0] d);
    @(negedge clk_i);
    dc_o = dc;
    d_o = d;
    wr_o = 1'b0;
    if (sty_o) begin
      repeat (4) @(negedge clk_i);
      rd_o = 1'b1;
    end
    repeat (4) @(negedge clk_i);
    rd_o = !sty_o;
    if (!sty_o) begin
      wr_o = 1'b1;
    end
    repeat (4) @(negedge clk_i);
    wr_o = 1'b1;
    d_o = ~d;
  endtask

  task automatic rd_on();
    @(negedge clk_i);
    rd_o = sty_o;
  endtask

  task automatic rd_off();
    @(negedge clk_i);
    rd_o = !sty_o;
  endtask

  // Serial clock runs only within a byte; bus pins stay fixed meanwhile
  task automatic ser(input logic dc, input logic [7:0] d, input int n);
    @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      si_o = d[7-i];
      dc_o = dc;
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    si_o = ~si_o;
  endtask
endmodule // lcdh_host_model
`default_nettype wire
